// File: shared/ram_ctl_defines.svh
// Purpose: Constants for the autosizing RAM controller
// Assumes: 32-bit address space, RAM packed at its top in 4 Mbyte blocks
// Notes:   Clock rates are given in kHz and turned into core cycle counts here
`ifndef RAM_CTL_DEFINES_SVH
`define RAM_CTL_DEFINES_SVH

`define CORE_CLK_KHZ   125000
`define XTAL_KHZ       33330
`define RAM_CLK_KHZ    (`XTAL_KHZ / 2)
// Round up so a RAM step never runs faster than the RAM clock allows
`define RAM_DIV        ((`CORE_CLK_KHZ + `RAM_CLK_KHZ - 1) / `RAM_CLK_KHZ)
`define DIV_W          4
`define ADDR_W         32
`define DATA_W         32
`define BYTES          4
`define BLOCK_LSB      22
`define BLOCK_MSB      31
`define BLOCK_IDX_W    10
`define WORD_ADDR_W    20
`define MAX_BLOCKS     4
`define HALF_W         16
`define HALF_SEL_BIT   1
`define BE_UPPER       4'hC
`define BE_LOWER       4'h3
`define BE_ALL         4'hF
`define ODD_PARITY     1'b1

`endif

// File: shared/ram_ctl_pkg.sv
// Purpose: Types shared by the RAM controller modules
// Assumes: ram_ctl_defines.svh supplies every width but those of the state and board fields
// Notes:   No constants live here, only types
`include "ram_ctl_defines.svh"

package ram_ctl_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_SELECT,
        ST_WRITE,
        ST_LATCH,
        ST_READ,
        ST_CHECK
    } ctl_state_type;

    typedef struct packed
    {
        ctl_state_type                 st;
        logic [`DIV_W-1:0]             div;
        logic                          tick;
        logic                          wr;
        logic                          half16;
        logic [`ADDR_W-1:0]            addr;
        logic [`BYTES-1:0]             be;
        logic [`DATA_W-1:0]            wdata;
        logic [`WORD_ADDR_W-1:0]       word_addr;
        logic [1:0]                    board;
        logic [`MAX_BLOCKS-1:0]        block;
        logic                          ram_en;
        logic [`DATA_W-1:0]            rbuf;
        logic [`BYTES-1:0]             rpar;
        logic [`DATA_W-1:0]            rdata;
        logic                          ack;
        logic                          miss;
        logic                          perr;
        logic                          flag;
    } ctl_reg_type;

endpackage

// File: shared/ram_sel_if.sv
// Purpose: Carries an address and board sizes to the decoder and back
// Assumes: Decoder is purely combinational
// Notes:   One modport per side
`timescale 1ns/1ns
`default_nettype none
`include "ram_ctl_defines.svh"

interface ram_sel_if;
    logic [`ADDR_W-1:0]      addr;
    logic                    main_8m;
    logic                    addon_present;
    logic                    addon_8m;
    logic                    hit;
    logic [1:0]              board_sel;
    logic [`MAX_BLOCKS-1:0]  block_sel;

    modport decoder (input addr, main_8m, addon_present, addon_8m,
                     output hit, board_sel, block_sel);
    modport ctrl    (output addr, main_8m, addon_present, addon_8m,
                     input hit, board_sel, block_sel);
endinterface

`default_nettype wire

// File: rtl/ram_autosize_decode.sv
// Purpose: Autosizing board and block select decode
// Assumes: Board sizes are static while accesses run
// Notes:   Block 0 of each board is its highest 4 Mbyte block
`timescale 1ns/1ns
`default_nettype none
`include "ram_ctl_defines.svh"

module ram_autosize_decode
(
    ram_sel_if.decoder bus
);
    logic [`BLOCK_IDX_W-1:0] from_top;
    logic [`BLOCK_IDX_W-1:0] main_blocks;
    logic [`BLOCK_IDX_W-1:0] addon_blocks;
    logic [`BLOCK_IDX_W-1:0] addon_idx;

    // Counting blocks down from the top puts main RAM at the top word
    assign from_top     = ~bus.addr[`BLOCK_MSB:`BLOCK_LSB];
    assign main_blocks  = bus.main_8m ? `BLOCK_IDX_W'(2)
                                      : `BLOCK_IDX_W'(1);
    // Add-on size counts only when the board is fitted
    assign addon_blocks = !bus.addon_present ? `BLOCK_IDX_W'(0)
                        : bus.addon_8m ? `BLOCK_IDX_W'(2)
                                       : `BLOCK_IDX_W'(1);
    assign addon_idx    = from_top - main_blocks;

    always_comb
    begin
        bus.hit       = 1'b0;
        bus.board_sel = 2'h0;
        bus.block_sel = `MAX_BLOCKS'(0);
        if (from_top < main_blocks)
        begin
            bus.hit          = 1'b1;
            bus.board_sel[0] = 1'b1;
            bus.block_sel[from_top[0]] = 1'b1;
        end
        else if (addon_idx < addon_blocks)
        begin
            bus.hit          = 1'b1;
            bus.board_sel[1] = 1'b1;
            bus.block_sel[2 + addon_idx[0]] = 1'b1;
        end
        // Anything lower selects nothing and no RAM answers
    end
endmodule

`default_nettype wire

// File: rtl/ram_controller.sv
// Purpose: RAM controller with autosizing, parity and 16-bit folding
// Assumes: RAM data and parity are valid two RAM steps after enable
// Notes:   RAM steps run on an enable pulse near the 16.67 MHz rate
`timescale 1ns/1ns
`default_nettype none
`include "ram_ctl_defines.svh"

module ram_controller
#(
    parameter int DIV_COUNT = `RAM_DIV
)
(
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      main_8m_in,
    input  wire logic                      addon_present_in,
    input  wire logic                      addon_8m_in,
    input  wire logic                      req_in,
    input  wire logic                      write_in,
    input  wire logic                      half16_in,
    input  wire logic [`ADDR_W-1:0]        addr_in,
    input  wire logic [`BYTES-1:0]         be_in,
    input  wire logic [`DATA_W-1:0]        wdata_in,
    output logic                           busy_out,
    output logic                           ack_out,
    output logic                           miss_out,
    output logic                           parity_err_out,
    output logic [`DATA_W-1:0]             rdata_out,
    input  wire logic                      parity_en_in,
    input  wire logic                      parity_flag_clr_in,
    output logic                           parity_flag_out,
    output logic [1:0]                     ram_board_sel_out,
    output logic [`MAX_BLOCKS-1:0]         ram_block_sel_out,
    output logic [`WORD_ADDR_W-1:0]        ram_word_addr_out,
    output logic                           ram_we_out,
    output logic [`BYTES-1:0]              ram_be_out,
    output logic [`DATA_W-1:0]             ram_wdata_out,
    output logic [`BYTES-1:0]              ram_wpar_out,
    input  wire logic [`DATA_W-1:0]        ram_rdata_in,
    input  wire logic [`BYTES-1:0]         ram_rpar_in
);
    // Refused at elaboration: below 2, or above what the divider counter can hold
    if (DIV_COUNT < 2 || DIV_COUNT > (1 << `DIV_W))
    begin : g_div_bad
        $error("DIV_COUNT out of range for the divider");
    end

    localparam logic [`DIV_W-1:0] DIV_LAST = `DIV_W'(DIV_COUNT - 1);

    ram_ctl_pkg::ctl_reg_type q;
    ram_ctl_pkg::ctl_reg_type d;
    ram_sel_if                sel ();

    logic [`BYTES-1:0]  wpar;
    logic [`BYTES-1:0]  rpar_calc;
    logic [`BYTES-1:0]  par_bad;

    ram_autosize_decode u_decode
    (
        .bus (sel.decoder)
    );

    assign sel.addr          = q.addr;
    assign sel.main_8m       = main_8m_in;
    assign sel.addon_present = addon_present_in;
    assign sel.addon_8m      = addon_8m_in;

    // Per-byte parity for the stored word and for the word read back
    genvar i;
    generate
        for (i = 0; i < `BYTES; i++)
        begin : g_par
            assign wpar[i]      = ^q.wdata[8*i +: 8] ^ `ODD_PARITY;
            assign rpar_calc[i] = ^q.rbuf[8*i +: 8] ^ `ODD_PARITY;
            assign par_bad[i]   = q.be[i] & (rpar_calc[i] ^ q.rpar[i]);
        end
    endgenerate

    always_comb
    begin
        d      = q;
        d.ack  = 1'b0;
        d.miss = 1'b0;
        d.perr = 1'b0;
        d.tick = 1'b0;

        // RAM step enable, divided down from the core clock
        if (q.div == DIV_LAST)
        begin
            d.div  = `DIV_W'(0);
            d.tick = 1'b1;
        end
        else
        begin
            d.div = q.div + `DIV_W'(1);
        end

        case (q.st)
            ram_ctl_pkg::ST_IDLE:
            begin
                if (req_in)
                begin
                    d.st     = ram_ctl_pkg::ST_SELECT;
                    d.wr     = write_in;
                    d.half16 = half16_in;
                    d.addr   = addr_in;
                    if (half16_in)
                    begin
                        d.wdata = {wdata_in[`HALF_W-1:0],
                                   wdata_in[`HALF_W-1:0]};
                        d.be    = addr_in[`HALF_SEL_BIT] ? `BE_LOWER
                                                         : `BE_UPPER;
                    end
                    else
                    begin
                        d.wdata = wdata_in;
                        d.be    = be_in;
                    end
                end
            end
            ram_ctl_pkg::ST_SELECT:
            begin
                if (q.tick)
                begin
                    if (sel.hit)
                    begin
                        d.board  = sel.board_sel;
                        d.block  = sel.block_sel;
                        d.ram_en = 1'b1;
                        d.st     = q.wr ? ram_ctl_pkg::ST_WRITE
                                        : ram_ctl_pkg::ST_LATCH;
                        if (q.wr)
                            d.word_addr = q.addr[`BLOCK_LSB-1:2];
                    end
                    else
                    begin
                        // Nothing is selected; the master is still answered
                        d.ack  = 1'b1;
                        d.miss = 1'b1;
                        d.st   = ram_ctl_pkg::ST_IDLE;
                    end
                end
            end
            ram_ctl_pkg::ST_WRITE:
            begin
                if (q.tick)
                begin
                    d.ram_en = 1'b0;
                    d.ack    = 1'b1;
                    d.st     = ram_ctl_pkg::ST_IDLE;
                end
            end
            ram_ctl_pkg::ST_LATCH:
            begin
                d.word_addr = q.addr[`BLOCK_LSB-1:2];
                if (q.tick)
                    d.st = ram_ctl_pkg::ST_READ;
            end
            ram_ctl_pkg::ST_READ:
            begin
                if (q.tick)
                begin
                    d.rbuf   = ram_rdata_in;
                    d.rpar   = ram_rpar_in;
                    d.ram_en = 1'b0;
                    d.st     = ram_ctl_pkg::ST_CHECK;
                end
            end
            ram_ctl_pkg::ST_CHECK:
            begin
                d.ack = 1'b1;
                d.st  = ram_ctl_pkg::ST_IDLE;
                if (parity_en_in && (|par_bad))
                begin
                    d.perr = 1'b1;
                end
                else if (q.half16)
                begin
                    d.rdata = {`HALF_W'(0),
                               q.addr[`HALF_SEL_BIT]
                                   ? q.rbuf[`HALF_W-1:0]
                                   : q.rbuf[`DATA_W-1:`HALF_W]};
                end
                else
                begin
                    d.rdata = q.rbuf;
                end
            end
            default:
            begin
                d.st     = ram_ctl_pkg::ST_IDLE;
                d.ram_en = 1'b0;
            end
        endcase

        // A parity error arriving with a clear still sets the flag
        if (parity_flag_clr_in)
            d.flag = 1'b0;
        if (d.perr)
            d.flag = 1'b1;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign busy_out          = (q.st != ram_ctl_pkg::ST_IDLE);
    assign ack_out           = q.ack;
    assign miss_out          = q.miss;
    assign parity_err_out    = q.perr;
    assign rdata_out         = q.rdata;
    assign parity_flag_out   = q.flag;
    assign ram_board_sel_out = q.ram_en ? q.board : 2'h0;
    assign ram_block_sel_out = q.ram_en ? q.block
                                        : `MAX_BLOCKS'(0);
    assign ram_word_addr_out = q.word_addr;
    // Write strobe only in the write step, so reads never store
    assign ram_we_out        = q.ram_en &&
                               (q.st == ram_ctl_pkg::ST_WRITE);
    assign ram_be_out        = q.ram_en ? q.be : `BYTES'(0);
    assign ram_wdata_out     = q.wdata;
    assign ram_wpar_out      = wpar;

endmodule

`default_nettype wire

// File: dv/ram_ctl_sva.sv
// Purpose: Port checks for ram_controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound into every ram_controller instance
`timescale 1ns/1ns
`default_nettype none
`include "ram_ctl_defines.svh"

module ram_ctl_sva
#(
    parameter int DIV_COUNT = 8
)
(
    input wire logic                    core_clk_in,
    input wire logic                    rst_n_in,
    input wire logic                    parity_en_in,
    input wire logic                    busy_out,
    input wire logic                    ack_out,
    input wire logic                    miss_out,
    input wire logic                    parity_err_out,
    input wire logic [`DATA_W-1:0]      rdata_out,
    input wire logic                    parity_flag_out,
    input wire logic [1:0]              ram_board_sel_out,
    input wire logic [`MAX_BLOCKS-1:0]  ram_block_sel_out,
    input wire logic [`WORD_ADDR_W-1:0] ram_word_addr_out,
    input wire logic                    ram_we_out,
    input wire logic [`DATA_W-1:0]      ram_wdata_out,
    input wire logic [`BYTES-1:0]       ram_wpar_out
);
    // Three RAM steps for a read, plus slack for the tick phase at take
    localparam int ACK_MAX = 4 * DIV_COUNT + 4;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_start;
        $rose(busy_out);
    endsequence
    sequence s_finish;
        ##[1:ACK_MAX] ack_out;
    endsequence

    chk_ack_bound: assert property (s_start |-> s_finish)
        else $error("access not answered in time");
    chk_miss_nosel: assert property (miss_out |->
        ram_board_sel_out == 2'h0 && $past(ram_board_sel_out) == 2'h0
        && ram_block_sel_out == 4'h0)
        else $error("select seen on a missed access");
    chk_block_onehot: assert property (ram_board_sel_out != 2'h0
        |-> $onehot(ram_block_sel_out))
        else $error("block select not one-hot");
    chk_board_match: assert property (ram_board_sel_out != 2'h0
        |-> ram_board_sel_out == ((|ram_block_sel_out[1:0]) ? 2'h1 : 2'h2))
        else $error("board select disagrees with block");
    chk_write_par: assert property (ram_we_out |->
        ram_board_sel_out != 2'h0
        && ram_wpar_out == {~^ram_wdata_out[31:24], ~^ram_wdata_out[23:16],
                            ~^ram_wdata_out[15:8], ~^ram_wdata_out[7:0]})
        else $error("write parity wrong or no select");
    // A read loads its word address in the first latch step, after select
    chk_addr_held: assert property (ram_board_sel_out != 2'h0
        && $past(ram_board_sel_out) != 2'h0
        && $past(ram_board_sel_out, 2) != 2'h0
        |-> $stable(ram_word_addr_out))
        else $error("word address moved during access");
    chk_perr_gate: assert property (parity_err_out |->
        parity_en_in && ack_out && !miss_out)
        else $error("parity error without enable or ack");
    chk_flag_set: assert property (parity_err_out |->
        ##[0:1] parity_flag_out)
        else $error("parity flag not set");
    chk_rdata_hold: assert property ($changed(rdata_out) |-> ack_out
        && !parity_err_out && !miss_out)
        else $error("read data changed outside a good read");
endmodule

bind ram_controller ram_ctl_sva #(.DIV_COUNT(DIV_COUNT)) ram_ctl_sva_inst
(
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .parity_en_in(parity_en_in), .busy_out(busy_out), .ack_out(ack_out),
    .miss_out(miss_out), .parity_err_out(parity_err_out),
    .rdata_out(rdata_out), .parity_flag_out(parity_flag_out),
    .ram_board_sel_out(ram_board_sel_out),
    .ram_block_sel_out(ram_block_sel_out),
    .ram_word_addr_out(ram_word_addr_out), .ram_we_out(ram_we_out),
    .ram_wdata_out(ram_wdata_out), .ram_wpar_out(ram_wpar_out)
);

`default_nettype wire

// File: dv/ram_array_model.sv
// Purpose: Behavioural RAM arrays of both boards with stored parity
// Assumes: Data is ready within one RAM step, well inside the two steps the controller allows
// Notes:   bad_par_in flips every returned parity bit on demand
`timescale 1ns/1ns
`default_nettype none
`include "ram_ctl_defines.svh"

module ram_array_model
(
    input  wire logic                    clk_in,
    input  wire logic [1:0]              board_sel_in,
    input  wire logic [`MAX_BLOCKS-1:0]  block_sel_in,
    input  wire logic [`WORD_ADDR_W-1:0] word_addr_in,
    input  wire logic                    we_in,
    input  wire logic [`BYTES-1:0]       be_in,
    input  wire logic [`DATA_W-1:0]      wdata_in,
    input  wire logic [`BYTES-1:0]       wpar_in,
    input  wire logic                    bad_par_in,
    output logic      [`DATA_W-1:0]      rdata_out,
    output logic      [`BYTES-1:0]       rpar_out
);
    logic [`DATA_W-1:0] dmem [logic [23:0]];
    logic [`BYTES-1:0]  pmem [logic [23:0]];
    logic [23:0]        key;

    assign key = {block_sel_in, word_addr_in};
    initial
    begin
        rdata_out = 32'h0;
        rpar_out  = 4'h0;
    end
    always @(posedge clk_in)
        if (board_sel_in != 2'h0 && we_in)
        begin
            if (!dmem.exists(key))
            begin
                dmem[key] = 32'h0;
                pmem[key] = 4'h0;
            end
            for (int b = 0; b < `BYTES; b++)
                if (be_in[b])
                begin
                    dmem[key][8*b +: 8] = wdata_in[8*b +: 8];
                    pmem[key][b] = wpar_in[b];
                end
        end
    // Unselected lines toggle so a stale value can never pass as data
    always @(negedge clk_in)
        if (board_sel_in != 2'h0 && !we_in && dmem.exists(key))
        begin
            rdata_out <= dmem[key];
            rpar_out  <= pmem[key] ^ {4{bad_par_in}};
        end
        else
        begin
            rdata_out <= ~rdata_out;
            rpar_out  <= ~rpar_out;
        end
endmodule

`default_nettype wire

// File: dv/tb.sv
// Purpose: Self-checking bench for ram_controller
// Assumes: Board sizes change only while the controller is idle
// Notes:   Inputs move on the falling edge; seed fixed for repeat runs
`timescale 1ns/1ns
`default_nettype none
`include "ram_ctl_defines.svh"

module tb;
    logic        clk, rst_n, m8, ap, a8, req, wr, h16, pen, fclr, bad;
    logic        busy, ack, miss, perr, flag, we;
    logic [31:0] addr, wd, rd, rwd, rrd, seed, a, d, low;
    logic [3:0]  be, blk, rbe, rwp, rrp, seen_k;
    logic [1:0]  bsel, seen_b;
    logic [19:0] wa;
    logic [15:0] h;
    logic [5:0]  e;
    logic [2:0]  cfgs [6] = '{3'h0, 3'h4, 3'h2, 3'h3, 3'h6, 3'h7};
    int          err_total, num_checks, nb, sel_cyc;

    ram_controller ram_controller_inst
    (
        .core_clk_in(clk), .rst_n_in(rst_n), .main_8m_in(m8),
        .addon_present_in(ap), .addon_8m_in(a8), .req_in(req),
        .write_in(wr), .half16_in(h16), .addr_in(addr), .be_in(be),
        .wdata_in(wd), .busy_out(busy), .ack_out(ack), .miss_out(miss),
        .parity_err_out(perr), .rdata_out(rd), .parity_en_in(pen),
        .parity_flag_clr_in(fclr), .parity_flag_out(flag),
        .ram_board_sel_out(bsel), .ram_block_sel_out(blk),
        .ram_word_addr_out(wa), .ram_we_out(we), .ram_be_out(rbe),
        .ram_wdata_out(rwd), .ram_wpar_out(rwp), .ram_rdata_in(rrd),
        .ram_rpar_in(rrp)
    );
    ram_array_model ram_array_model_inst
    (
        .clk_in(clk), .board_sel_in(bsel), .block_sel_in(blk),
        .word_addr_in(wa), .we_in(we), .be_in(rbe), .wdata_in(rwd),
        .wpar_in(rwp), .bad_par_in(bad), .rdata_out(rrd), .rpar_out(rrp)
    );

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Blocks counted down from the top of the space
    function automatic logic [5:0] exp_sel(input logic [31:0] x);
        int k;
        int mb;
        int ab;
        k  = int'(10'h3FF - x[31:22]);
        mb = m8 ? 2 : 1;
        ab = ap ? (a8 ? 2 : 1) : 0;
        if (k < mb)
            return {2'h1, 4'(1 << k)};
        if (k < mb + ab)
            return {2'h2, 4'(1 << (2 + k - mb))};
        return 6'h00;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic access(input logic w, input logic hf,
                          input logic [31:0] x, input logic [31:0] dv);
        int n;
        @(negedge clk);
        req = 1'b1;
        wr = w;
        h16 = hf;
        addr = x;
        wd = dv;
        @(negedge clk);
        req = 1'b0;
        seen_b = 2'h0;
        seen_k = 4'h0;
        sel_cyc = 0;
        for (n = 0; n < 60 && ack !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
            seen_b |= bsel;
            seen_k |= blk;
            if (bsel != 2'h0)
                sel_cyc++;
        end
        chk("ack", 32'h1, {31'h0, ack});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #(8 * 20000);
        err_total++;
        final_report();
    end
    initial
    begin
        {rst_n, m8, ap, a8, req, wr, h16, fclr, bad} = 9'h0;
        {addr, wd, be, pen, seed} = {64'h0, 4'hF, 1'b1, 32'h8F9C};
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        foreach (cfgs[i])
        begin
            @(negedge clk);
            {m8, ap, a8} = cfgs[i];
            nb = (m8 ? 2 : 1) + (ap ? (a8 ? 2 : 1) : 0);
            low = 32'h0 - (32'(nb) << 22);
            for (int j = 0; j < 3; j++)
            begin
                a = (j == 0) ? 32'hFFFF_FFFC : (j == 1) ? low
                    : (low + rnd() % (32'(nb) << 22)) & 32'hFFFF_FFFC;
                d = rnd();
                e = exp_sel(a);
                access(1'b1, 1'b0, a, d);
                chk("wr_board", 32'(e[5:4]), 32'(seen_b));
                chk("wr_len", 32'(`RAM_DIV), 32'(sel_cyc));
                access(1'b0, 1'b0, a, 32'h0);
                chk("rd_block", 32'(e[3:0]), 32'(seen_k));
                chk("rd_len", 32'(2 * `RAM_DIV), 32'(sel_cyc));
                chk("rd_data", d, rd);
            end
            access(1'b0, 1'b0, low - 32'h4, 32'h0);
            chk("miss", 32'h1, {31'h0, miss});
            chk("miss_board", 32'h0, {30'h0, seen_b});
        end
        // Corrupt parity: flagged when enabled, ignored when not
        d = rnd();
        access(1'b1, 1'b0, 32'hFF00_1000, d);
        access(1'b0, 1'b0, 32'hFF00_1000, 32'h0);
        bad = 1'b1;
        access(1'b0, 1'b0, 32'hFF00_1000, 32'h0);
        chk("perr_on", 32'h1, {31'h0, perr});
        @(posedge clk);
        #1;
        chk("flag", 32'h1, {31'h0, flag});
        chk("rd_kept", d, rd);
        @(negedge clk);
        pen = 1'b0;
        access(1'b0, 1'b0, 32'hFF00_1000, 32'h0);
        chk("perr_off", 32'h0, {31'h0, perr});
        @(negedge clk);
        {bad, pen, fclr} = 3'h3;
        @(negedge clk);
        fclr = 1'b0;
        chk("flag_clr", 32'h0, {31'h0, flag});
        // 16-bit master: upper half written, both halves read back low
        d = rnd();
        a = rnd();
        h = a[15:0];
        access(1'b1, 1'b0, 32'hFFC0_0010, d);
        access(1'b1, 1'b1, 32'hFFC0_0010, {16'h0, h});
        access(1'b0, 1'b0, 32'hFFC0_0010, 32'h0);
        chk("fold_wr", {h, d[15:0]}, rd);
        access(1'b0, 1'b1, 32'hFFC0_0010, 32'h0);
        chk("fold_up", {16'h0, h}, rd);
        access(1'b0, 1'b1, 32'hFFC0_0012, 32'h0);
        chk("fold_lo", {16'h0, d[15:0]}, rd);
        final_report();
    end
endmodule

`default_nettype wire
